//--- rtl/gpio_cfg_pkg.sv
// Constants for the pin configuration registers of GPIO group 5.
package gpio_cfg_pkg;
  localparam int          NUM_PINS        = 3;
  localparam logic [7:0]  OFF_PIN51       = 8'h40;
  localparam logic [7:0]  OFF_PIN52       = 8'h41;
  localparam logic [7:0]  OFF_PIN53       = 8'h42;
  localparam logic [7:0]  CFG_RESET       = 8'h01;
  localparam logic [7:0]  CFG_WMASK       = 8'h8F;
  localparam int          BIT_DIR         = 0;
  localparam int          BIT_POL         = 1;
  localparam int          FN_LO           = 2;
  localparam int          FN_HI           = 3;
  localparam int          BIT_OD          = 7;
  localparam logic [1:0]  FN_GPIO         = 2'h0;
  localparam logic [1:0]  FN_SERIAL       = 2'h1;
  localparam logic [1:0]  FN_IRQ          = 2'h2;
  localparam logic [1:0]  FN_RSVD         = 2'h3;
  localparam logic [31:0] UNMAPPED_RDATA  = 32'h0000_0000;
endpackage

//--- rtl/cfg_bus_if.sv
// Interface carrying the stored configuration values to the pin muxes.
`timescale 1ns/1ns
`default_nettype none
interface cfg_bus_if;
  logic [7:0] cfg [3];
  modport regs (output cfg);
  modport pins (input cfg);
endinterface
`default_nettype wire

//--- rtl/gpio_cfg_regs.sv
// Storage for the pin configuration registers with write mask.
`timescale 1ns/1ns
`default_nettype none
module gpio_cfg_regs
  import gpio_cfg_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  // Write port
  input  wire logic [2:0] we_i,
  input  wire logic [7:0] wdata_i,
  // Stored values
  cfg_bus_if.regs         cfg_if
);
  genvar g;
  generate
    for (g = 0; g < NUM_PINS; g++)
    begin : g_reg
      logic [7:0] cfg_q;
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          cfg_q <= CFG_RESET;
        end
        else if (ce_i && we_i[g])
        begin
          // Reserved bits 6:4 are never stored, so they read as zero.
          cfg_q <= wdata_i & CFG_WMASK;
        end
      end
      assign cfg_if.cfg[g] = cfg_q;
    end
  endgenerate
endmodule
`default_nettype wire

//--- rtl/gpio_pin_config_port5.sv
// Top level: Wishbone slave and pin muxing for GPIO pins 5.1 to 5.3.
// Operation
// - bit0 one input, zero output drives data
// - bit1 inverts pin on read and drive
// - bits3:2 select GPIO, serial, IRQ, reserved
// - bit7 one open drain, zero push-pull
`timescale 1ns/1ns
`default_nettype none
module gpio_pin_config_port5
  import gpio_cfg_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // GPIO data path
  input  wire logic [2:0]  gpio_data_out_i,
  output logic      [2:0]  gpio_data_in_o,
  // Alternate function sources and sinks
  input  wire logic [2:0]  irq_level_i,
  output logic      [2:0]  irq_pin_o,
  output logic             second_serial_carrier_detect_o,
  output logic             second_serial_receive_input_o,
  output logic      [2:0]  pin_fn_o,
  // Pads
  input  wire logic [2:0]  pad_i,
  output logic      [2:0]  pad_o,
  output logic      [2:0]  pad_oe_o
);
  cfg_bus_if cfg_if ();

  logic       req;
  logic [2:0] we;
  logic [7:0] rd;
  logic       hit;

  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  // Address decode; only byte lane 0 carries a register.
  always_comb
  begin
    hit = 1'b1;
    rd  = 8'h00;
    we  = 3'h0;
    unique case (wb_adr_i)
      OFF_PIN51: rd = cfg_if.cfg[0];
      OFF_PIN52: rd = cfg_if.cfg[1];
      OFF_PIN53: rd = cfg_if.cfg[2];
      default:   hit = 1'b0;
    endcase
    if (req && wb_we_i && wb_sel_i[0])
    begin
      we[0] = (wb_adr_i == OFF_PIN51);
      we[1] = (wb_adr_i == OFF_PIN52);
      we[2] = (wb_adr_i == OFF_PIN53);
    end
  end

  gpio_cfg_regs u_regs (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .we_i    (we),
    .wdata_i (wb_dat_i[7:0]),
    .cfg_if  (cfg_if)
  );

  // Single-cycle acknowledge: every access, mapped or not, is answered.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      wb_ack_o <= req;
      if (req && !wb_we_i)
      begin
        wb_dat_o <= hit ? {24'h00_0000, rd} : UNMAPPED_RDATA;
      end
    end
  end

  // Pin muxing is registered so every output comes from a flip-flop.
  logic [2:0] data_in_d;
  logic [2:0] pad_d;
  logic [2:0] oe_d;
  logic [2:0] irq_d;
  logic [2:0] fn_d;
  logic       dcd_d;
  logic       rxd_d;

  always_comb
  begin
    dcd_d = 1'b1;
    rxd_d = 1'b1;
    for (int i = 0; i < NUM_PINS; i++)
    begin
      logic [7:0] c;
      logic [1:0] fn;
      logic       val;
      logic       inv;
      c   = cfg_if.cfg[i];
      fn  = c[FN_HI:FN_LO];
      inv = c[BIT_POL];
      val = 1'b0;
      fn_d[i]      = (fn == FN_GPIO);
      data_in_d[i] = pad_i[i] ^ inv;
      irq_d[i]     = 1'b0;
      unique case (fn)
        FN_GPIO:   val = gpio_data_out_i[i] ^ inv;
        FN_IRQ:
        begin
          val      = irq_level_i[i] ^ inv;
          irq_d[i] = 1'b1;
        end
        FN_SERIAL:
        begin
          val = 1'b0;
          if (i == 1)
          begin
            dcd_d = pad_i[i] ^ inv;
          end
          if (i == 2)
          begin
            rxd_d = pad_i[i] ^ inv;
          end
        end
        FN_RSVD:   val = 1'b0;
      endcase
      // Serial functions only take input, so they never drive the pad.
      if (c[BIT_DIR] || fn == FN_SERIAL || fn == FN_RSVD)
      begin
        oe_d[i]  = 1'b0;
        pad_d[i] = 1'b0;
      end
      else if (c[BIT_OD])
      begin
        oe_d[i]  = !val;
        pad_d[i] = 1'b0;
      end
      else
      begin
        oe_d[i]  = 1'b1;
        pad_d[i] = val;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      gpio_data_in_o                 <= 3'h0;
      pad_o                          <= 3'h0;
      pad_oe_o                       <= 3'h0;
      irq_pin_o                      <= 3'h0;
      pin_fn_o                       <= 3'h7;
      second_serial_carrier_detect_o <= 1'b1;
      second_serial_receive_input_o  <= 1'b1;
    end
    else if (ce_i)
    begin
      gpio_data_in_o                 <= data_in_d;
      pad_o                          <= pad_d;
      pad_oe_o                       <= oe_d;
      irq_pin_o                      <= irq_d;
      pin_fn_o                       <= fn_d;
      second_serial_carrier_detect_o <= dcd_d;
      second_serial_receive_input_o  <= rxd_d;
    end
  end
endmodule
`default_nettype wire

//--- tb/gpio_cfg_checker_properties.sv
// Port-level checker for the GPIO group 5 pin configuration block.
`timescale 1ns/1ns
`default_nettype none
module gpio_cfg_checker (
  input wire logic       clk_i, rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_ack_o,
  input wire logic [2:0] irq_pin_o, pin_fn_o, pad_oe_o,
  input wire logic       second_serial_carrier_detect_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o ##1 (!wb_ack_o || !$past(ce_i));
  endproperty
  property p_nodrive;
    (pad_oe_o & ~(pin_fn_o | irq_pin_o)) == 3'h0;
  endproperty
  property p_rst;
    $fell(rst_i) |-> pad_oe_o == 3'h0 && pin_fn_o == 3'h7 && irq_pin_o == 3'h0;
  endproperty
  property p_fn;
    (irq_pin_o & pin_fn_o) == 3'h0;
  endproperty
  property p_cd;
    pin_fn_o[1] || irq_pin_o[1] |-> second_serial_carrier_detect_o;
  endproperty
  a_ack: assert property (p_ack) else $error("ack not a one cycle answer");
  a_rst: assert property (p_rst) else $error("pin outputs off after reset");
  a_fn: assert property (p_fn) else $error("pin in two functions");
  a_cd: assert property (p_cd) else $error("carrier detect not idle");
  a_nodrive: assert property (p_nodrive) else $error("serial or reserved pin driven");
  c_ack: cover property (wb_ack_o);
  c_irq: cover property (irq_pin_o != 3'h0);
  c_oe: cover property (pad_oe_o != 3'h0);
  c_ser: cover property (!pin_fn_o[1] && !irq_pin_o[1]);
endmodule
bind gpio_pin_config_port5 gpio_cfg_checker gpio_cfg_checker_i (.clk_i, .rst_i, .ce_i,
  .wb_cyc_i, .wb_stb_i, .wb_ack_o, .irq_pin_o, .pin_fn_o, .pad_oe_o,
  .second_serial_carrier_detect_o);
`default_nettype wire

//--- tb/tb.sv
// Self-checking bench for the GPIO group 5 pin configuration block.
`timescale 1ns/1ns
`default_nettype none
module tb;
  import gpio_cfg_pkg::*;
  logic clk_i = 0, rst_i = 1, ce_i = 1, cyc = 0, stb = 0, we = 0, cd, rx, ack;
  logic [7:0] adr = 0, m [3];
  logic [3:0] sel = 0;
  logic [31:0] wd = 0, rd, got;
  logic [2:0] dout = 0, irq = 0, pad = 0, din, irqo, fn, po, oe;
  int miscompares = 0, n_checks = 0;
  always #10 clk_i = ~clk_i;
  gpio_pin_config_port5 gpio_pin_config_port5_i (.clk_i, .rst_i, .ce_i, .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd),
    .wb_dat_o(rd), .wb_ack_o(ack), .gpio_data_out_i(dout), .gpio_data_in_o(din),
    .irq_level_i(irq), .irq_pin_o(irqo), .second_serial_carrier_detect_o(cd),
    .second_serial_receive_input_o(rx), .pin_fn_o(fn), .pad_i(pad), .pad_o(po),
    .pad_oe_o(oe));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("CHECK FAILED %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Ack is sampled at the edge itself, so read data is the value it carried.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic s);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    sel <= {3'h0, s};
    do @(posedge clk_i); while (ack !== 1'b1);
    got = rd;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rdall;
    for (int k = 0; k < 4; k++)
    begin
      bus(1'b0, OFF_PIN51 + 8'(k), 32'h0, 1'b1);
      chk(got, k < 3 ? {24'h0, m[k]} : UNMAPPED_RDATA);
    end
  endtask
  // The inputs are passed in, so a frozen block can be held against older inputs.
  task automatic pins(input logic [8:0] inp);
    logic [7:0] c;
    logic [2:0] od, oq, op;
    logic v;
    logic drv;
    {od, oq, op} = inp;
    for (int k = 0; k < 3; k++)
    begin
      c = m[k];
      v = (c[3:2] == FN_IRQ ? oq[k] : od[k]) ^ c[1];
      drv = !c[0] && (c[3:2] == FN_GPIO || c[3:2] == FN_IRQ);
      chk(fn[k], c[3:2] == FN_GPIO);
      chk(irqo[k], c[3:2] == FN_IRQ);
      chk(din[k], op[k] ^ c[1]);
      chk(oe[k], drv && !(c[7] && v));
      chk(po[k], drv && !c[7] && v);
    end
    chk(cd, m[1][3:2] == FN_SERIAL ? op[1] ^ m[1][1] : 1'b1);
    chk(rx, m[2][3:2] == FN_SERIAL ? op[2] ^ m[2][1] : 1'b1);
  endtask
  initial
  begin
    #400000;
    miscompares++;
    end_sim();
  end
  initial
  begin
    logic [7:0] a;
    logic [31:0] d;
    logic s;
    logic [8:0] p;
    void'($urandom(32'h9C8546E4));
    for (int k = 0; k < 3; k++) m[k] = CFG_RESET;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    pins({dout, irq, pad});
    rdall();
    repeat (200)
    begin
      a = 8'($urandom_range(3));
      d = $urandom;
      s = 1'($urandom);
      {dout, irq, pad} <= 9'($urandom);
      bus(1'b1, OFF_PIN51 + a, d, s);
      if (a < 3 && s) m[a] = d[7:0] & CFG_WMASK;
      bus(1'b0, OFF_PIN51 + a, 32'h0, 1'b1);
      chk(got, a < 3 ? {24'h0, m[a]} : UNMAPPED_RDATA);
      @(posedge clk_i);
      pins({dout, irq, pad});
    end
    // Clock enable low must hold every output although the inputs move.
    @(posedge clk_i);
    p = {dout, irq, pad};
    ce_i <= 1'b0;
    {dout, irq, pad} <= ~p;
    repeat (2) @(posedge clk_i);
    pins(p);
    ce_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    pins({dout, irq, pad});
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int k = 0; k < 3; k++) m[k] = CFG_RESET;
    rdall();
    end_sim();
  end
endmodule
`default_nettype wire
